// *** logic/flash_read.v ***
// Serial flash read engine (device side) plus its byte prefetch FIFO.
// Assumes a host driving CS_N and SCLK (mode 0), and an array read port
// that returns MEM_RDATA one cycle after MEM_RD is seen.
`include "flash_read_map.vh"
`default_nettype none

// ==========================================
// Prefetch FIFO
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PW-1:0]    wr_q;
    reg [PW-1:0]    rd_q;
    reg [PW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[PW:0]);
    assign out_valid = (cnt_q != {(PW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= {PW{1'b0}};
            rd_q  <= {PW{1'b0}};
            cnt_q <= {(PW+1){1'b0}};
        end else if (flush) begin
            wr_q  <= {PW{1'b0}};
            rd_q  <= {PW{1'b0}};
            cnt_q <= {(PW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end
endmodule

// ==========================================
// Read engine
module flash_read #(
    parameter AW    = `ADDR_BITS,
    parameter DEPTH = 16
) (
    // Clock and reset
    input  wire          CLOCK,
    input  wire          RST_N,
    // Serial link pins
    input  wire          CS_N,
    input  wire          SCLK,
    input  wire [3:0]    IO_IN,
    output reg  [3:0]    IO_OUT,
    output reg  [3:0]    IO_OE,
    // Array read port
    output reg           MEM_RD,
    output reg  [AW-1:0] MEM_ADDR,
    input  wire [7:0]    MEM_RDATA,
    // Status and configuration
    input  wire          BUSY,
    input  wire          QUAD_ENABLE,
    input  wire          QUAD_CMD_MODE,
    input  wire [1:0]    DUMMY_SEL,
    input  wire          MODE_RESET,
    // Observation
    output reg           CONT_MODE,
    output reg           REJECTED
);
    localparam ST_OPC   = 3'd0;
    localparam ST_ADDR  = 3'd1;
    localparam ST_MODE  = 3'd2;
    localparam ST_DUMMY = 3'd3;
    localparam ST_DATA  = 3'd4;
    localparam ST_REJ   = 3'd5;

    // Lines per clock of address and mode phases
    function [2:0] addr_w;
        input [7:0] op;
        input       quad_command_mode;
        begin
            if (quad_command_mode || op == `OP_QUAD_IO) addr_w = 3'd4;
            else if (op == `OP_DUAL_IO)   addr_w = 3'd2;
            else                          addr_w = 3'd1;
        end
    endfunction

    // Lines per clock of the data phase
    function [2:0] data_w;
        input [7:0] op;
        input       quad_command_mode;
        begin
            if (quad_command_mode || op == `OP_QUAD_OUT || op == `OP_QUAD_IO) data_w = 3'd4;
            else if (op == `OP_DUAL_OUT || op == `OP_DUAL_IO)   data_w = 3'd2;
            else                                                data_w = 3'd1;
        end
    endfunction

    // Dummy clocks after address, or after mode byte
    function [4:0] dummy_clk;
        input [7:0] op;
        input       quad_command_mode;
        input [1:0] sel;
        begin
            case (op)
                `OP_READ:     dummy_clk = 5'd0;
                `OP_FAST_READ: begin
                    if (!quad_command_mode)           dummy_clk = `DUMMY_CLK_BYTE;
                    else if (sel == 2'd0) dummy_clk = `DUMMY_CLK_SEL0;
                    else if (sel == 2'd1) dummy_clk = `DUMMY_CLK_SEL1;
                    else if (sel == 2'd2) dummy_clk = `DUMMY_CLK_SEL2;
                    else                dummy_clk = `DUMMY_CLK_SEL3;
                end
                `OP_DUAL_IO:  dummy_clk = `DUMMY_CLK_IO;
                `OP_QUAD_IO:  dummy_clk = `DUMMY_CLK_IO;
                default:      dummy_clk = `DUMMY_CLK_BYTE;
            endcase
        end
    endfunction

    // Pin synchronisers
    reg        cs_m_q, cs_s_q;
    reg        ck_m_q, ck_s_q, ck_p_q;
    reg  [3:0] io_m_q, io_s_q;
    // Decoder
    reg  [2:0]    st_q;
    reg  [4:0]    cnt_q;
    reg  [7:0]    cmd_q;
    reg  [31:0]   sh_q;
    reg  [31:0]   sh_d;
    reg  [2:0]    in_w;
    // Fetch and serializer
    reg  [AW-1:0] addr_q;
    reg           fetch_q;
    reg           pend_q;
    reg           flush_q;
    reg  [7:0]    out_sh_q;
    reg  [3:0]    left_q;
    reg  [7:0]    byte_v;
    reg  [2:0]    dw;
    wire          rise;
    wire          fall;
    wire          fifo_rdy;
    wire          fifo_vld;
    wire [7:0]    fifo_dat;
    wire [7:0]    opc;
    wire          known;
    wire          needs_quad;
    wire [4:0]    addr_len;
    wire [4:0]    dum_len;
    wire          has_mode;
    wire          pop;

    assign rise = ck_s_q & ~ck_p_q & ~cs_s_q;
    assign fall = ~ck_s_q & ck_p_q & ~cs_s_q & (st_q == ST_DATA);
    assign opc  = sh_d[7:0];
    assign known = (opc == `OP_READ) || (opc == `OP_FAST_READ) || (opc == `OP_DUAL_OUT) ||
                   (opc == `OP_DUAL_IO) || (opc == `OP_QUAD_OUT) || (opc == `OP_QUAD_IO);
    assign needs_quad = QUAD_CMD_MODE || (opc == `OP_QUAD_OUT) || (opc == `OP_QUAD_IO);
    assign addr_len = (addr_w(cmd_q, QUAD_CMD_MODE) == 3'd4) ? `ADDR_CLK_X4 :
                      (addr_w(cmd_q, QUAD_CMD_MODE) == 3'd2) ? `ADDR_CLK_X2 : `ADDR_CLK_X1;
    assign dum_len  = dummy_clk(cmd_q, QUAD_CMD_MODE, DUMMY_SEL);
    assign has_mode = (cmd_q == `OP_DUAL_IO) || (cmd_q == `OP_QUAD_IO);
    assign pop      = fall && (left_q == 4'd0);

    // Shift in at the width of the current phase
    always @* begin
        in_w = (st_q == ST_OPC) ? (QUAD_CMD_MODE ? 3'd4 : 3'd1) : addr_w(cmd_q, QUAD_CMD_MODE);
        if (in_w == 3'd4)      sh_d = {sh_q[27:0], io_s_q};
        else if (in_w == 3'd2) sh_d = {sh_q[29:0], io_s_q[1:0]};
        else                   sh_d = {sh_q[30:0], io_s_q[0]};
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            ck_m_q <= 1'b0;
            ck_s_q <= 1'b0;
            ck_p_q <= 1'b0;
            io_m_q <= 4'h0;
            io_s_q <= 4'h0;
        end else begin
            cs_m_q <= CS_N;
            cs_s_q <= cs_m_q;
            ck_m_q <= SCLK;
            ck_s_q <= ck_m_q;
            ck_p_q <= ck_s_q;
            io_m_q <= IO_IN;
            io_s_q <= io_m_q;
        end
    end

    // ==========================================
    // Command decoder
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_q      <= ST_OPC;
            cnt_q     <= 5'd0;
            cmd_q     <= 8'h00;
            sh_q      <= 32'h0000_0000;
            addr_q    <= {AW{1'b0}};
            fetch_q   <= 1'b0;
            flush_q   <= 1'b0;
            CONT_MODE <= `CONT_RST;
            REJECTED  <= 1'b0;
        end else begin
            flush_q <= 1'b0;
            if (cs_s_q) begin
                // Keeps opcode skip alive across frames when armed
                st_q     <= CONT_MODE ? (BUSY ? ST_REJ : ST_ADDR) : ST_OPC;
                REJECTED <= CONT_MODE & BUSY;
                cnt_q    <= 5'd0;
                fetch_q  <= 1'b0;
                flush_q  <= 1'b1;
                if (MODE_RESET) begin
                    CONT_MODE <= `CONT_RST;
                end
            end else if (rise) begin
                sh_q  <= sh_d;
                cnt_q <= cnt_q + 5'd1;
                // A mode capture later in this branch still wins
                if (MODE_RESET) CONT_MODE <= `CONT_RST;
                case (st_q)
                    ST_OPC: begin
                        if (cnt_q == (QUAD_CMD_MODE ? `OPC_CLK_QUAD : `OPC_CLK_SINGLE) - 5'd1) begin
                            cnt_q <= 5'd0;
                            cmd_q <= opc;
                            if (!known || BUSY || (needs_quad && !QUAD_ENABLE)) begin
                                st_q     <= ST_REJ;
                                REJECTED <= known;
                            end else begin
                                st_q <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (cnt_q == addr_len - 5'd1) begin
                            cnt_q   <= 5'd0;
                            addr_q  <= sh_d[AW-1:0];
                            fetch_q <= 1'b1;
                            flush_q <= 1'b1;
                            if (has_mode)            st_q <= ST_MODE;
                            else if (dum_len == 5'd0) st_q <= ST_DATA;
                            else                     st_q <= ST_DUMMY;
                        end
                    end
                    ST_MODE: begin
                        if (cnt_q == ((addr_w(cmd_q, QUAD_CMD_MODE) == 3'd4) ?
                                      `MODE_CLK_X4 : `MODE_CLK_X2) - 5'd1) begin
                            cnt_q     <= 5'd0;
                            st_q      <= ST_DUMMY;
                            // Value takes effect only after CS next toggles
                            CONT_MODE <= (sh_d[`CONT_MSB:`CONT_LSB] == `CONT_KEEP);
                        end
                    end
                    ST_DUMMY: begin
                        if (cnt_q == dum_len - 5'd1) begin
                            cnt_q <= 5'd0;
                            st_q  <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        cnt_q <= 5'd0;
                    end
                    ST_REJ: begin
                        cnt_q <= 5'd0;
                    end
                    default: begin
                        st_q <= ST_OPC;
                    end
                endcase
            end else if (MODE_RESET) begin
                CONT_MODE <= `CONT_RST;
            end
            if (fetch_q && !MEM_RD && !pend_q && fifo_rdy && !flush_q) begin
                addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ==========================================
    // Array fetch into the FIFO
    // Room is checked at issue; no other writer can take it meanwhile
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_RD   <= 1'b0;
            MEM_ADDR <= {AW{1'b0}};
            pend_q   <= 1'b0;
        end else begin
            MEM_RD <= 1'b0;
            pend_q <= MEM_RD & ~flush_q;
            if (flush_q || cs_s_q) begin
                pend_q <= 1'b0;
            end else if (fetch_q && !MEM_RD && !pend_q && fifo_rdy) begin
                MEM_RD   <= 1'b1;
                MEM_ADDR <= addr_q;
            end
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .flush     (flush_q),
        .in_valid  (pend_q),
        .in_ready  (fifo_rdy),
        .in_data   (MEM_RDATA),
        .out_valid (fifo_vld),
        .out_ready (pop),
        .out_data  (fifo_dat)
    );

    // ==========================================
    // Output serializer on falling edges
    always @* begin
        dw     = data_w(cmd_q, QUAD_CMD_MODE);
        byte_v = (left_q == 4'd0) ? (fifo_vld ? fifo_dat : 8'hff) : out_sh_q;
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            IO_OUT   <= 4'h0;
            IO_OE    <= 4'h0;
            out_sh_q <= 8'h00;
            left_q   <= 4'd0;
        end else if (cs_s_q || st_q != ST_DATA) begin
            IO_OE  <= 4'h0;
            left_q <= 4'd0;
        end else if (fall) begin
            out_sh_q <= byte_v << dw;
            left_q   <= ((left_q == 4'd0) ? `BYTE_BITS : left_q) - {1'b0, dw};
            if (dw == 3'd4) begin
                IO_OUT <= byte_v[7:4];
                IO_OE  <= 4'hf;
            end else if (dw == 3'd2) begin
                IO_OUT <= {2'b00, byte_v[7:6]};
                IO_OE  <= 4'h3;
            end else begin
                IO_OUT <= {2'b00, byte_v[7], 1'b0};
                IO_OE  <= 4'h2;
            end
        end
    end
endmodule

`default_nettype wire

// *** logic/flash_read_map.vh ***
// Constants of the serial flash read engine: opcodes, phase lengths, resets.
// Assumes inclusion by bare name from the design file only.
`ifndef FLASH_READ_MAP_VH
`define FLASH_READ_MAP_VH

// ==========================================
// Read opcodes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0b
`define OP_DUAL_OUT      8'h3b
`define OP_DUAL_IO       8'hbb
`define OP_QUAD_OUT      8'h6b
`define OP_QUAD_IO       8'heb

// ==========================================
// Phase lengths in serial clocks
`define OPC_CLK_SINGLE   5'd8
`define OPC_CLK_QUAD     5'd2
`define ADDR_CLK_X1      5'd24
`define ADDR_CLK_X2      5'd12
`define ADDR_CLK_X4      5'd6
`define MODE_CLK_X2      5'd4
`define MODE_CLK_X4      5'd2
`define DUMMY_CLK_BYTE   5'd8
`define DUMMY_CLK_IO     5'd4
`define DUMMY_CLK_SEL0   5'd4
`define DUMMY_CLK_SEL1   5'd6
`define DUMMY_CLK_SEL2   5'd8
`define DUMMY_CLK_SEL3   5'd8

// ==========================================
// Field values and reset values
`define CONT_KEEP        2'b10
`define CONT_MSB         5
`define CONT_LSB         4
`define BYTE_BITS        4'd8
`define ADDR_BITS        24
`define CONT_RST         1'b0

`endif

// *** tb/flash_read_chk.sv ***
// Port checker for the serial flash read engine.
// Assumes a bind to flash_read; every signal is sampled on CLOCK, though CS_N and SCLK are asynchronous pins.
`default_nettype none
module flash_read_chk #(
    parameter int AW = 24
) (
    // Clock and reset
    input wire logic          CLOCK,
    input wire logic          RST_N,
    // Link
    input wire logic          CS_N,
    input wire logic          SCLK,
    input wire logic [3:0]    IO_OUT,
    input wire logic [3:0]    IO_OE,
    // Array port and status
    input wire logic          MEM_RD,
    input wire logic [AW-1:0] MEM_ADDR,
    input wire logic          QUAD_ENABLE,
    input wire logic          MODE_RESET,
    input wire logic          CONT_MODE,
    input wire logic          REJECTED
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ==========================================
    // Helpers
    // A fetch counts as a step only inside one frame
    logic [AW-1:0] last_q;
    logic          run_q;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            last_q <= '0;
            run_q  <= 1'b0;
        end else begin
            run_q <= !CS_N && (run_q || MEM_RD);
            if (MEM_RD) last_q <= MEM_ADDR;
        end
    end
    sequence cs_idle;
        CS_N [*5];
    endsequence
    sequence sclk_held;
        SCLK [*4];
    endsequence
    // ==========================================
    // Properties
    a_idle_release: assert property (cs_idle |-> IO_OE == 4'h0)
        else $error("lines driven with chip select high");
    a_edge_hold: assert property (sclk_held |-> $stable(IO_OUT) && $stable(IO_OE))
        else $error("data changed while serial clock high");
    a_lane_shape: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal drive lane set");
    a_reject_quiet: assert property (REJECTED |-> IO_OE == 4'h0)
        else $error("rejected command drives lines");
    a_fetch_gap: assert property (MEM_RD |=> !MEM_RD ##1 !MEM_RD)
        else $error("array fetches too close");
    a_addr_step: assert property (MEM_RD && run_q && !CS_N |-> MEM_ADDR == last_q + 1'b1)
        else $error("fetch address did not advance by one");
    a_quad_gate: assert property ($rose(IO_OE == 4'hf) |-> QUAD_ENABLE)
        else $error("four lines driven without quad enable");
    a_mode_clear: assert property (CS_N && MODE_RESET |=> !CONT_MODE)
        else $error("mode reset left skip active");
    a_cont_frame: assert property ($rose(CONT_MODE) |-> !CS_N)
        else $error("skip mode set outside a frame");
endmodule
`default_nettype wire

// *** tb/link_host.sv ***
// Host controller model for the serial link, mode 0, clock idles low.
// Assumes the bench calls its tasks one at a time.
`default_nettype none
module link_host (
    // Link outputs
    output var logic       CS_N,
    output var logic       SCLK,
    output var logic [3:0] IO_IN,
    // Device drive
    input wire logic [3:0] IO_OUT,
    input wire logic [3:0] IO_OE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] hv, ho, fill;
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        hv = 4'h0;
        ho = 4'h0;
        fill = 4'h5;
    end
    // Released lines toggle so a stale level never passes
    always #24 fill = ~fill;
    always_comb begin
        for (int i = 0; i < 4; i++) IO_IN[i] = ho[i] ? hv[i] : IO_OE[i] ? IO_OUT[i] : fill[i];
    end
    task automatic frame(input logic on);
        if (on) begin
            CS_N = 1'b0;
            #24;
        end else begin
            #24 CS_N = 1'b1;
            ho = 4'h0;
            #48;
        end
    endtask
    // Bits change with SCLK low, taken by the device at the rise
    task automatic send(input logic [31:0] v, input int n, input int w);
        for (int i = 0; i < n; i++) begin
            ho = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
            hv = (w == 1) ? {3'h0, v[31]} : (w == 2) ? {2'h0, v[31:30]} : v[31:28];
            v = v << w;
            #24 SCLK = 1'b1;
            #24 SCLK = 1'b0;
        end
    endtask
    task automatic recv(input int w, output logic [7:0] b, output logic [3:0] oe);
        ho = 4'h0;
        for (int i = 0; i < 8 / w; i++) begin
            #24 SCLK = 1'b1;
            b = (w == 1) ? {b[6:0], IO_IN[1]} : (w == 2) ? {b[5:0], IO_IN[1:0]} : {b[3:0], IO_IN};
            oe = IO_OE;
            #24 SCLK = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/flash_read_tb.sv ***
// Self-checking bench for the flash read engine.
// Assumes the host model and a one-cycle array model built here.
`default_nettype none
module flash_read_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK = 1'b0, RST_N = 1'b0, CS_N, SCLK, MEM_RD, CONT_MODE, REJECTED;
    logic BUSY, QUAD_ENABLE, QUAD_CMD_MODE, MODE_RESET, oe_seen;
    logic [3:0] IO_IN, IO_OUT, IO_OE;
    logic [1:0] DUMMY_SEL;
    logic [23:0] MEM_ADDR;
    logic [7:0] MEM_RDATA = 8'h00;
    logic [7:0] ub;
    logic [3:0] uo;
    int fails = 0, checks = 0;
    always #2.5 CLOCK = ~CLOCK;
    flash_read flash_read_inst (.CLOCK, .RST_N, .CS_N, .SCLK, .IO_IN, .IO_OUT, .IO_OE,
        .MEM_RD, .MEM_ADDR, .MEM_RDATA, .BUSY, .QUAD_ENABLE, .QUAD_CMD_MODE, .DUMMY_SEL,
        .MODE_RESET, .CONT_MODE, .REJECTED);
    link_host link_host_inst (.CS_N, .SCLK, .IO_IN, .IO_OUT, .IO_OE);
    // ==========================================
    // Array model and helpers
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction
    always @(posedge CLOCK) if (MEM_RD) MEM_RDATA <= pat(MEM_ADDR);
    always @(posedge CLOCK) if (|IO_OE) oe_seen <= 1'b1;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One frame: opcode (wo lanes, 0 = skipped), address, mode, dummies, data
    task automatic rd(input logic [7:0] op, input int wo, wa, mc, input logic [7:0] md,
                      input int dc, wd, input logic [23:0] a, input int n, input logic rej);
        logic [7:0] b;
        logic [3:0] oe;
        oe_seen = 1'b0;
        link_host_inst.frame(1'b1);
        if (wo > 0) link_host_inst.send({op, 24'h0}, 8 / wo, wo);
        link_host_inst.send({a, 8'h0}, 24 / wa, wa);
        if (mc > 0) link_host_inst.send({md, 24'h0}, mc, 8 / mc);
        link_host_inst.send(32'h0, dc, 1);
        for (int i = 0; i < n; i++) begin
            link_host_inst.recv(wd, b, oe);
            if (!rej) chk("byte", b, pat(24'(a + i)));
        end
        if (!rej) chk("lanes", 8'(oe), wd == 1 ? 8'h2 : wd == 2 ? 8'h3 : 8'hf);
        chk("refused", 8'(REJECTED), 8'(rej));
        chk("drove", 8'(oe_seen), 8'(!rej));
        link_host_inst.frame(1'b0);
        chk("released", 8'(IO_OE), 8'h0);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        BUSY = 1'b0;
        QUAD_ENABLE = 1'b1;
        QUAD_CMD_MODE = 1'b0;
        DUMMY_SEL = 2'h0;
        MODE_RESET = 1'b0;
        repeat (5) @(negedge CLOCK);
        RST_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        rd(8'h03, 1, 1, 0, 8'h0, 0, 1, 24'h123456, 2, 0);
        rd(8'h0b, 1, 1, 0, 8'h0, 8, 1, 24'hfffffe, 3, 0);
        rd(8'h3b, 1, 1, 0, 8'h0, 8, 2, 24'h00ff80, 2, 0);
        rd(8'h6b, 1, 1, 0, 8'h0, 8, 4, 24'h400001, 2, 0);
        $display("plain reads done");
        rd(8'hbb, 1, 2, 4, 8'h20, 4, 2, 24'h0a0b0c, 2, 0);
        chk("skip on", 8'(CONT_MODE), 8'h1);
        rd(8'hbb, 0, 2, 4, 8'h00, 4, 2, 24'h0a1000, 1, 0);
        chk("skip off", 8'(CONT_MODE), 8'h0);
        rd(8'hbb, 1, 2, 4, 8'hff, 4, 2, 24'h777777, 1, 0);
        rd(8'heb, 1, 4, 2, 8'ha5, 4, 4, 24'h3c3c3c, 2, 0);
        rd(8'heb, 0, 4, 2, 8'ha5, 4, 4, 24'h000100, 1, 0);
        @(negedge CLOCK) MODE_RESET = 1'b1;
        @(negedge CLOCK) MODE_RESET = 1'b0;
        @(negedge CLOCK) chk("mode reset", 8'(CONT_MODE), 8'h0);
        rd(8'heb, 1, 4, 2, 8'h00, 4, 4, 24'h0000ff, 1, 0);
        $display("skip mode done");
        @(negedge CLOCK) BUSY = 1'b1;
        rd(8'h0b, 1, 1, 0, 8'h0, 8, 1, 24'h000010, 1, 1);
        rd(8'hbb, 1, 2, 4, 8'h00, 4, 2, 24'h000010, 1, 1);
        @(negedge CLOCK) BUSY = 1'b0;
        QUAD_ENABLE = 1'b0;
        rd(8'h6b, 1, 1, 0, 8'h0, 8, 4, 24'h000020, 1, 1);
        rd(8'heb, 1, 4, 2, 8'h00, 4, 4, 24'h000020, 1, 1);
        @(negedge CLOCK) QUAD_ENABLE = 1'b1;
        $display("refusals done");
        QUAD_CMD_MODE = 1'b1;
        for (int s = 0; s < 4; s++) begin
            @(negedge CLOCK) DUMMY_SEL = 2'(s);
            rd(8'h0b, 4, 4, 0, 8'h0, s == 0 ? 4 : s == 1 ? 6 : 8, 4, 24'h500000 + 24'(s), 2, 0);
        end
        @(negedge CLOCK) QUAD_CMD_MODE = 1'b0;
        $display("quad command mode done");
        // Raise chip select three bits into a byte
        link_host_inst.frame(1'b1);
        link_host_inst.send({8'h03, 24'h000040}, 32, 1);
        link_host_inst.send(32'h0, 3, 1);
        link_host_inst.frame(1'b0);
        chk("abort", 8'(IO_OE), 8'h0);
        rd(8'h03, 1, 1, 0, 8'h0, 0, 1, 24'h000041, 1, 0);
        // Unknown opcode: ignored, but not flagged as a refused read
        link_host_inst.frame(1'b1);
        link_host_inst.send({8'h9f, 24'h0}, 32, 1);
        link_host_inst.recv(1, ub, uo);
        chk("unknown refused", 8'(REJECTED), 8'h0);
        chk("unknown lanes", 8'(uo), 8'h0);
        link_host_inst.frame(1'b0);
        $display("abort done");
        give_verdict();
    end
    // Hang guard: far beyond the longest expected run
    initial begin
        #400us;
        fails++;
        give_verdict();
    end
endmodule
bind flash_read flash_read_chk #(.AW(AW)) chk_inst (.CLOCK, .RST_N, .CS_N, .SCLK, .IO_OUT,
    .IO_OE, .MEM_RD, .MEM_ADDR, .QUAD_ENABLE, .MODE_RESET, .CONT_MODE, .REJECTED);
`default_nettype wire
